// File: ccap_edge.sv
// edge detector for one capture channel
// assumes pin input already synchronised to aclk
`timescale 1ns/1ps
module ccap_edge
  import ccap_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       clk_en,
  input  wire logic       pin_sync,
  input  wire ccap_cfg_s  cfg,
  output ccap_edge_s      edges
);
  logic level;
  logic prev_q;
  assign level = pin_sync ^ cfg.inv;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_q <= 1'b0;
    end else if (clk_en) begin
      prev_q <= level;
    end
  end
  assign edges.rise = clk_en & level & ~prev_q;
  assign edges.fall = clk_en & ~level & prev_q;
endmodule : ccap_edge

// File: ccap_monitor.sv
// port assertions for the capture slice
// assumes clk_en held high and a bind onto ccap_top
`timescale 1ns/1ps
module ccap_monitor
  import ccap_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [1:0]  cap_pin,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        irq
);
  logic [7:0] ra_q;
  wire        rd_ctrl = ra_q == CCAP_OFS_CTRL;
  wire        rd_lat  = ra_q inside {CCAP_OFS_RISE2, CCAP_OFS_FALL2, CCAP_OFS_RISE3, CCAP_OFS_FALL3};
  wire        rd_bad  = !(rd_ctrl || rd_lat || ra_q inside
                          {CCAP_OFS_IRQ_STAT, CCAP_OFS_IRQ_EN, CCAP_OFS_IRQ_CLR});
  always_ff @(posedge aclk)
    if (s_axi_arvalid && s_axi_arready)
      ra_q <= s_axi_araddr;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_ctrl_rsvd: assert property (s_axi_rvalid && rd_ctrl |-> (s_axi_rdata & 32'hff20_ff20) == 0)
    else $error("reserved control bits read nonzero");
  a_latch_upper: assert property (s_axi_rvalid && rd_lat |-> s_axi_rdata[31:16] == 16'h0)
    else $error("latch upper bits nonzero");
  a_bad_addr: assert property (s_axi_rvalid && rd_bad |-> s_axi_rresp == CCAP_RESP_SLVERR
    && s_axi_rdata == 0)
    else $error("unmapped read not refused");
  a_irq_cause: assert property ($rose(irq) |-> $rose(s_axi_bvalid)
    || ($past(s_axi_bvalid) && !$past(s_axi_bvalid, 2))
    || $past(cap_pin, 2) != $past(cap_pin, 6))
    else $error("irq rose without pin edge or write");
  a_read_lat: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
    else $error("read answer late");
  a_write_lat: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while response pending");
  a_r_taken: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response not released");
  c_irq: cover property ($rose(irq));
  c_bad: cover property (s_axi_rvalid && rd_bad);
  c_wr: cover property (s_axi_bvalid);
endmodule : ccap_monitor
bind ccap_top ccap_monitor mon (.*);

// File: ccap_pin_src.sv
// pin source standing in for the external capture inputs
// assumes the bench sets the wanted levels; pins move off the clock edge
`timescale 1ns/1ps
module ccap_pin_src (
  input  wire logic       aclk,
  input  wire logic [1:0] lvl,
  output logic      [1:0] cap_pin = 2'h0
);
  // driven on the falling edge, half a cycle away from the rising sampling edge
  always @(negedge aclk) cap_pin <= lvl;
endmodule : ccap_pin_src

// File: ccap_pkg.sv
// package for the capture control slice, channels 2 and 3
// assumes an AXI4-Lite slave with 32-bit data, one word per register
package ccap_pkg;
  localparam logic [7:0] CCAP_OFS_CTRL      = 8'h54;
  localparam logic [7:0] CCAP_OFS_RISE2     = 8'h68;
  localparam logic [7:0] CCAP_OFS_FALL2     = 8'h6c;
  localparam logic [7:0] CCAP_OFS_RISE3     = 8'h70;
  localparam logic [7:0] CCAP_OFS_FALL3     = 8'h74;
  localparam logic [7:0] CCAP_OFS_IRQ_STAT  = 8'h80;
  localparam logic [7:0] CCAP_OFS_IRQ_EN    = 8'h84;
  localparam logic [7:0] CCAP_OFS_IRQ_CLR   = 8'h88;
  // field positions within a channel's 8-bit lane
  localparam int CCAP_B_INV   = 0;
  localparam int CCAP_B_RIE   = 1;
  localparam int CCAP_B_FIE   = 2;
  localparam int CCAP_B_CEN   = 3;
  localparam int CCAP_B_IF    = 4;
  localparam int CCAP_B_RLF   = 6;
  localparam int CCAP_B_FLF   = 7;
  localparam int CCAP_LANE_CH2 = 0;
  localparam int CCAP_LANE_CH3 = 16;
  localparam logic [7:0]  CCAP_LANE_RW_MASK = 8'h0f;
  localparam logic [31:0] CCAP_CTRL_RESET   = 32'h0000_0000;
  localparam logic [15:0] CCAP_LATCH_RESET  = 16'h0000;
  localparam int CCAP_CNT_W = 16;
  localparam logic [1:0] CCAP_RESP_OKAY   = 2'b00;
  localparam logic [1:0] CCAP_RESP_SLVERR = 2'b10;
  // msb first: lane bit 3 down to lane bit 0
  typedef struct packed {
    logic cap_en;
    logic fall_ie;
    logic rise_ie;
    logic inv;
  } ccap_cfg_s;
  typedef struct packed {
    logic rise;
    logic fall;
  } ccap_edge_s;
endpackage : ccap_pkg

// File: ccap_top.sv
// capture control slice for channels 2 and 3 with AXI4-Lite registers
// assumes pin inputs are asynchronous; counter and polarity on aclk
//
// Local design decisions: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module ccap_top
  import ccap_pkg::*;
#(
  parameter int CNT_W = CCAP_CNT_W
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             clk_en,
  input  wire logic [1:0]       cap_pin,
  input  wire logic [CNT_W-1:0] pwm_count,
  input  wire logic             flag_clear_polarity,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [7:0]       s_axi_awaddr,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  output logic [1:0]            s_axi_bresp,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  input  wire logic [7:0]       s_axi_araddr,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready,
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  irq
);
  // pin synchroniser
  logic [1:0] pin_s1_q;
  logic [1:0] pin_s2_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1_q <= 2'b00;
      pin_s2_q <= 2'b00;
    end else if (clk_en) begin
      pin_s1_q <= cap_pin;
      pin_s2_q <= pin_s1_q;
    end
  end

  // per-channel state, index 0 = channel 2, index 1 = channel 3
  ccap_cfg_s        cfg_q   [2];
  logic [1:0]       irqf_q;
  logic [1:0]       rlf_q;
  logic [1:0]       flf_q;
  logic [CNT_W-1:0] rise_val_q [2];
  logic [CNT_W-1:0] fall_val_q [2];
  logic [1:0]       stat_q;
  logic [1:0]       en_q;

  // write channel: capture address and data independently
  logic       aw_have_q;
  logic       w_have_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic       wr_fire;
  logic       wr_ok;
  logic       ctrl_wr;
  logic       clr_wr;
  logic       en_wr;

  // no handshake is offered while the block is frozen
  assign s_axi_awready = clk_en & ~aw_have_q & ~s_axi_bvalid;
  assign s_axi_wready  = clk_en & ~w_have_q & ~s_axi_bvalid;
  assign wr_fire = clk_en & aw_have_q & w_have_q & ~s_axi_bvalid;
  assign ctrl_wr = wr_fire & (aw_addr_q[7:2] == CCAP_OFS_CTRL[7:2]);
  assign clr_wr  = wr_fire & (aw_addr_q[7:2] == CCAP_OFS_IRQ_CLR[7:2]);
  assign en_wr   = wr_fire & (aw_addr_q[7:2] == CCAP_OFS_IRQ_EN[7:2]);
  assign wr_ok   = ctrl_wr | clr_wr | en_wr;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
    end else if (clk_en) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_have_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_have_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= CCAP_RESP_OKAY;
    end else if (clk_en) begin
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? CCAP_RESP_OKAY : CCAP_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // channel logic
  ccap_edge_s edges [2];
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_ch
      localparam int LANE = (ch == 0) ? CCAP_LANE_CH2 : CCAP_LANE_CH3;
      localparam int BYTE = LANE / 8;
      logic [7:0] wlane;
      logic       lane_wr;
      logic       cap_rise;
      logic       cap_fall;
      logic       if_set;
      logic       rl_clr;
      logic       fl_clr;

      assign wlane   = w_data_q[LANE +: 8];
      assign lane_wr = ctrl_wr & w_strb_q[BYTE];

      ccap_edge u_edge (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .clk_en   (clk_en),
        .pin_sync (pin_s2_q[ch]),
        .cfg      (cfg_q[ch]),
        .edges    (edges[ch])
      );

      assign cap_rise = edges[ch].rise & cfg_q[ch].cap_en;
      assign cap_fall = edges[ch].fall & cfg_q[ch].cap_en;
      assign if_set = (cap_rise & cfg_q[ch].rise_ie)
                    | (cap_fall & cfg_q[ch].fall_ie);
      assign rl_clr = lane_wr & (wlane[CCAP_B_RLF] == flag_clear_polarity);
      assign fl_clr = lane_wr & (wlane[CCAP_B_FLF] == flag_clear_polarity);

      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          cfg_q[ch]      <= CCAP_CTRL_RESET[LANE +: 4];
          irqf_q[ch]     <= 1'b0;
          rlf_q[ch]      <= 1'b0;
          flf_q[ch]      <= 1'b0;
          rise_val_q[ch] <= CNT_W'(CCAP_LATCH_RESET);
          fall_val_q[ch] <= CNT_W'(CCAP_LATCH_RESET);
          stat_q[ch]     <= 1'b0;
          en_q[ch]       <= 1'b0;
        end else if (clk_en) begin
          if (lane_wr) begin
            cfg_q[ch] <= wlane[3:0] & CCAP_LANE_RW_MASK[3:0];
          end
          // set wins over clear on every flag
          if (if_set) begin
            irqf_q[ch] <= 1'b1;
          end else if (lane_wr && wlane[CCAP_B_IF]) begin
            irqf_q[ch] <= 1'b0;
          end
          if (cap_rise) begin
            rlf_q[ch]      <= 1'b1;
            rise_val_q[ch] <= pwm_count;
          end else if (rl_clr) begin
            rlf_q[ch] <= 1'b0;
          end
          if (cap_fall) begin
            flf_q[ch]      <= 1'b1;
            fall_val_q[ch] <= pwm_count;
          end else if (fl_clr) begin
            flf_q[ch] <= 1'b0;
          end
          if (if_set) begin
            stat_q[ch] <= 1'b1;
          end else if (clr_wr && w_data_q[ch]) begin
            stat_q[ch] <= 1'b0;
          end
          if (en_wr) begin
            en_q[ch] <= w_data_q[ch];
          end
        end
      end
    end
  endgenerate

  assign irq = |(stat_q & en_q);

  // control register image, reserved bits zero
  logic [7:0]  lane_img [2];
  logic [31:0] ctrl_img;
  assign lane_img[0] = {flf_q[0], rlf_q[0], 1'b0, irqf_q[0], cfg_q[0]};
  assign lane_img[1] = {flf_q[1], rlf_q[1], 1'b0, irqf_q[1], cfg_q[1]};
  assign ctrl_img = {8'h00, lane_img[1], 8'h00, lane_img[0]};

  // read channel
  logic [31:0] rd_word;
  logic        rd_hit;
  logic [5:0]  ra;
  assign ra = s_axi_araddr[7:2];
  assign s_axi_arready = clk_en & ~s_axi_rvalid;
  always_comb begin
    rd_hit  = 1'b1;
    rd_word = 32'h0000_0000;
    if (ra == CCAP_OFS_CTRL[7:2]) begin
      rd_word = ctrl_img;
    end else if (ra == CCAP_OFS_RISE2[7:2]) begin
      rd_word = 32'(rise_val_q[0]);
    end else if (ra == CCAP_OFS_FALL2[7:2]) begin
      rd_word = 32'(fall_val_q[0]);
    end else if (ra == CCAP_OFS_RISE3[7:2]) begin
      rd_word = 32'(rise_val_q[1]);
    end else if (ra == CCAP_OFS_FALL3[7:2]) begin
      rd_word = 32'(fall_val_q[1]);
    end else if (ra == CCAP_OFS_IRQ_STAT[7:2]) begin
      rd_word = {30'h0000_0000, stat_q};
    end else if (ra == CCAP_OFS_IRQ_EN[7:2]) begin
      rd_word = {30'h0000_0000, en_q};
    end else if (ra == CCAP_OFS_IRQ_CLR[7:2]) begin
      rd_word = 32'h0000_0000;
    end else begin
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= CCAP_RESP_OKAY;
    end else if (clk_en) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_hit ? CCAP_RESP_OKAY : CCAP_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule : ccap_top

// File: tb_capture_control_ch2_ch3.sv
// self-checking bench for the capture slice
// assumes ccap_top, its monitor and the pin source compiled first
`timescale 1ns/1ps
module tb_capture_control_ch2_ch3
  import ccap_pkg::*;
;
  logic        aclk = 1'b0, aresetn = 1'b0, flag_clear_polarity = 1'b0, irq;
  logic [1:0]  lvl = 2'h0, cap_pin, s_axi_bresp, s_axi_rresp, wresp;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic [15:0] pwm_count = 16'h0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  int          errors = 0, total_checks = 0, cyc = 0;
  ccap_top dut (.*, .clk_en(1'b1));
  ccap_pin_src src (.aclk(aclk), .lvl(lvl), .cap_pin(cap_pin));
  always #50 aclk = ~aclk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic ta, tw, pa, pw;
    pa = 1'b1;
    pw = 1'b1;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    // ready seen mid-cycle is the value the next rising edge samples
    while (pa || pw) begin
      @(negedge aclk);
      ta = pa && s_axi_awready;
      tw = pw && s_axi_wready;
      @(posedge aclk);
      if (ta) begin
        s_axi_awvalid <= 1'b0;
        pa = 1'b0;
      end
      if (tw) begin
        s_axi_wvalid <= 1'b0;
        pw = 1'b0;
      end
    end
    do @(negedge aclk); while (!s_axi_bvalid);
    wresp = s_axi_bresp;
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge aclk); while (!s_axi_arready);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    do @(negedge aclk); while (!s_axi_rvalid);
    v = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask : rd
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [1:0] r;
    rd(a, d, r);
    chk(d, e);
  endtask : rc
  task automatic pin(input logic [1:0] v);
    @(posedge aclk);
    lvl <= v;
    repeat (8) @(posedge aclk);
  endtask : pin
  task automatic ci(input logic e);
    @(negedge aclk);
    chk({31'h0, irq}, {31'h0, e});
    @(posedge aclk);
  endtask : ci
  task automatic tally_and_finish;
    if (errors == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : tally_and_finish
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      tally_and_finish;
    end
  end
  initial begin
    logic [1:0] r;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rc(CCAP_OFS_CTRL, 32'h0);
    rc(CCAP_OFS_RISE2, 32'h0);
    wr(CCAP_OFS_CTRL, 32'hfffe_fffe);
    rc(CCAP_OFS_CTRL, 32'h000e_000e);
    wr(CCAP_OFS_IRQ_EN, 32'h3);
    chk({30'h0, wresp}, {30'h0, CCAP_RESP_OKAY});
    pwm_count <= 16'h1234;
    pin(2'b01);
    rc(CCAP_OFS_CTRL, 32'h000e_005e);
    ci(1'b1);
    rc(CCAP_OFS_RISE2, 32'h1234);
    wr(CCAP_OFS_CTRL, 32'h000e_00de);
    wr(CCAP_OFS_IRQ_CLR, 32'h1);
    rc(CCAP_OFS_CTRL, 32'h000e_004e);
    ci(1'b0);
    pwm_count <= 16'h0abc;
    pin(2'b00);
    rc(CCAP_OFS_CTRL, 32'h000e_00de);
    ci(1'b1);
    rc(CCAP_OFS_FALL2, 32'h0abc);
    flag_clear_polarity <= 1'b1;
    wr(CCAP_OFS_CTRL, 32'h000e_00de);
    rc(CCAP_OFS_CTRL, 32'h000e_000e);
    wr(CCAP_OFS_IRQ_CLR, 32'h3);
    ci(1'b0);
    pwm_count <= 16'hbeef;
    wr(CCAP_OFS_CTRL, 32'h0009_000e);
    repeat (8) @(posedge aclk);
    rc(CCAP_OFS_CTRL, 32'h0049_000e);
    rc(CCAP_OFS_RISE3, 32'hbeef);
    ci(1'b0);
    flag_clear_polarity <= 1'b0;
    wr(CCAP_OFS_CTRL, 32'h0009_000e);
    rc(CCAP_OFS_CTRL, 32'h0009_000e);
    pwm_count <= 16'h5555;
    wr(CCAP_OFS_CTRL, 32'h0000_0006);
    pin(2'b01);
    rc(CCAP_OFS_CTRL, 32'h0000_0006);
    rc(CCAP_OFS_RISE2, 32'h1234);
    ci(1'b0);
    rd(8'h40, d, r);
    chk({d[29:0], r}, {30'h0, CCAP_RESP_SLVERR});
    wr(8'h40, 32'hffff_ffff);
    chk({30'h0, wresp}, {30'h0, CCAP_RESP_SLVERR});
    s_axi_wstrb <= 4'h1;
    wr(CCAP_OFS_CTRL, 32'h0001_0001);
    rc(CCAP_OFS_CTRL, 32'h0000_0001);
    s_axi_wstrb <= 4'hf;
    tally_and_finish;
  end
endmodule : tb_capture_control_ch2_ch3
